// *** common/gsss_pkg.sv ***
// constants for the dual-channel safe-stop block
// assumes a 10 MHz system clock and an apb slave port
package gsss_pkg;
    localparam int DATA_W  = 32;
    localparam int ADDR_W  = 12;
    // register byte offsets
    localparam logic [ADDR_W-1:0] REG_CTRL   = 12'h000;
    localparam logic [ADDR_W-1:0] REG_MODE   = 12'h004;
    localparam logic [ADDR_W-1:0] REG_STATUS = 12'h008;
    localparam logic [ADDR_W-1:0] REG_TRIP   = 12'h00c;
    localparam logic [ADDR_W-1:0] REG_FUNC   = 12'h010;
    localparam logic [ADDR_W-1:0] REG_POL    = 12'h014;
    localparam logic [ADDR_W-1:0] REG_IRQ_ST = 12'h018;
    localparam logic [ADDR_W-1:0] REG_IRQ_MK = 12'h01c;
    // control bits
    localparam int CTRL_RUN      = 0;
    localparam int CTRL_TRIP_CLR = 1;
    // safety input mode
    localparam int         MODE_W       = 2;
    localparam logic [1:0] MODE_NO_TRIP = 2'h0;
    localparam logic [1:0] MODE_TRIP    = 2'h1;
    localparam logic [1:0] MODE_RST     = 2'h0;
    // terminal function and polarity codes
    localparam logic [7:0] FUNC_SAFETY_A = 8'h4d;
    localparam logic [7:0] FUNC_SAFETY_B = 8'h4e;
    localparam logic [7:0] FUNC_MONITOR  = 8'h3e;
    localparam logic [7:0] FUNC_NONE     = 8'hff;
    localparam logic [7:0] POL_NC        = 8'h01;
    localparam logic [7:0] POL_NO        = 8'h00;
    // trip codes
    localparam logic [7:0] TRIP_NONE   = 8'h00;
    localparam logic [7:0] TRIP_SAFETY = 8'h25;
    localparam logic [7:0] TRIP_EXT    = 8'h0c;
    // synchronised pin indices
    localparam int NSYNC  = 5;
    localparam int SY_A   = 0;
    localparam int SY_B   = 1;
    localparam int SY_SSW = 2;
    localparam int SY_MSW = 3;
    localparam int SY_EXT = 4;
    // status bits above the synchronised pins
    localparam int ST_GATE = 5;
    localparam int ST_MON  = 6;
    localparam int ST_TRIP = 7;
    // interrupt bits
    localparam int IRQ_W       = 3;
    localparam int IRQ_SHUTOFF = 0;
    localparam int IRQ_TRIP    = 1;
    localparam int IRQ_SKEW    = 2;
    // shutoff timing
    localparam longint SHUTOFF_MAX_NS  = 10_000_000;
    localparam longint CLK_PERIOD_NS   = 100;
    localparam int     SHUTOFF_MAX_CYC =
        int'(SHUTOFF_MAX_NS / CLK_PERIOD_NS);
    localparam int     SHUTOFF_LAT_CYC = 3;
endpackage : gsss_pkg

// *** hdl/gsss_top.sv ***
// dual-channel safe-stop logic with apb registers and interrupt
// assumes safety pins are asynchronous and high while energised
//
// Notes on behaviour
// (RL1) either safety input de-energised stops all output switching
// (RL2) one channel open: output stops, monitor stays inactive
// (RL3) monitor conducts only when both safety inputs de-energised
// (RL4) switching permitted only while both safety inputs energised
// (RL5) safety switch forces inputs 3/4 to safety functions, closed, locked
// (RL6) monitor switch forces output 11 to monitor, normally open, locked
// (RL7) switch off: assigned terminals revert to no function, contacts off
// (RL8) mode 00: hardware shutoff without entering trip
// (RL9) mode 01: hardware shutoff then trip with safety trip code
// (RL10) safety trip code outranks external trip code
// (RL11) output switched off well within 10 ms of an input opening
// (RL12) external device opens both channels together to demand stop
// (RL13) external device checks monitor output, missing confirm is fault
// (RL14) each safety input synchronised on its own before use
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module gsss_top #(
    parameter int SHUTOFF_MAX_CYC = gsss_pkg::SHUTOFF_MAX_CYC
) (
    // clock and reset
    input  wire logic                          CLK_SYS,
    input  wire logic                          RESETN,
    // apb slave
    input  wire logic                          PSEL,
    input  wire logic                          PENABLE,
    input  wire logic                          PWRITE,
    input  wire logic [gsss_pkg::ADDR_W-1:0]   PADDR,
    input  wire logic [gsss_pkg::DATA_W-1:0]   PWDATA,
    output logic      [gsss_pkg::DATA_W-1:0]   PRDATA,
    output logic                               PREADY,
    output logic                               PSLVERR,
    // safety pins and switches
    input  wire logic                          SAFETY_IN_A,
    input  wire logic                          SAFETY_IN_B,
    input  wire logic                          SAFETY_SW,
    input  wire logic                          MONITOR_SW,
    input  wire logic                          EXT_TRIP,
    // power stage, monitor, trip and interrupt
    output logic                               GATE_ENABLE,
    output logic                               STOP_MONITOR_OUT,
    output logic                               TRIP_ACTIVE,
    output logic                               IRQ
);
    import gsss_pkg::*;

    logic [NSYNC-1:0]  pins;
    logic [NSYNC-1:0]  sync;
    logic              safety_on;
    logic              mon_on;
    logic              a_ok;
    logic              b_ok;
    logic              shutoff;
    logic              trip_safety;
    logic              ext_req;
    logic              trip_clr;
    logic              next_gate;
    logic              next_mon;
    logic              run;
    logic [MODE_W-1:0] mode;
    logic [7:0]        trip_code;
    logic [7:0]        in3_fn;
    logic [7:0]        in4_fn;
    logic [7:0]        out11_fn;
    logic [7:0]        in3_pol;
    logic [7:0]        in4_pol;
    logic [7:0]        out11_pol;
    logic [IRQ_W-1:0]  cond;
    logic [IRQ_W-1:0]  cond_d;
    logic [IRQ_W-1:0]  evt;
    logic [IRQ_W-1:0]  irq_status;
    logic [IRQ_W-1:0]  irq_mask;
    logic              setup;
    logic              wr_en;
    logic [DATA_W-1:0] rd_data;
    logic              rd_err;

    // two-stage synchroniser per pin, no shared stage
    assign pins = {EXT_TRIP, MONITOR_SW, SAFETY_SW, SAFETY_IN_B, SAFETY_IN_A};
    generate
        for (genvar i = 0; i < NSYNC; i++) begin : g_sync
            logic s1;
            logic s2;
            always_ff @(posedge CLK_SYS or negedge RESETN) begin // RL14
                if (!RESETN) begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                end else begin
                    s1 <= pins[i];
                    s2 <= s1;
                end
            end
            assign sync[i] = s2;
        end
    endgenerate

    assign safety_on = sync[SY_SSW];
    assign mon_on    = sync[SY_MSW];
    assign a_ok      = sync[SY_A];
    assign b_ok      = sync[SY_B];
    assign ext_req   = sync[SY_EXT];

    // with the safety switch off the inputs carry no function
    assign shutoff     = safety_on && !(a_ok && b_ok); // RL1
    assign trip_safety = shutoff && (mode == MODE_TRIP); // RL9
    assign next_gate   = run && !shutoff && !TRIP_ACTIVE; // RL4
    assign next_mon    = safety_on && mon_on && !a_ok && !b_ok; // RL3

    // apb handshake: one wait-free access phase
    assign setup = PSEL && !PENABLE;
    assign wr_en = PSEL && PENABLE && PWRITE && PREADY;
    assign trip_clr = wr_en && (PADDR == REG_CTRL) && PWDATA[CTRL_TRIP_CLR];

    // power stage and monitor outputs
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            GATE_ENABLE      <= 1'b0;
            STOP_MONITOR_OUT <= 1'b0;
        end else begin
            GATE_ENABLE      <= next_gate; // RL1 RL11
            STOP_MONITOR_OUT <= next_mon; // RL2 RL3
        end
    end

    // trip state; safety code outranks external, set beats clear
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            TRIP_ACTIVE <= 1'b0;
            trip_code   <= TRIP_NONE;
        end else if (trip_safety) begin // RL9 RL10
            TRIP_ACTIVE <= 1'b1;
            trip_code   <= TRIP_SAFETY;
        end else if (ext_req && trip_code != TRIP_SAFETY) begin // RL10
            TRIP_ACTIVE <= 1'b1;
            trip_code   <= TRIP_EXT;
        end else if (trip_clr) begin // RL8
            TRIP_ACTIVE <= 1'b0;
            trip_code   <= TRIP_NONE;
        end
    end

    // terminal assignment follows the switches and cannot be written
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            in3_fn    <= FUNC_NONE;
            in4_fn    <= FUNC_NONE;
            in3_pol   <= POL_NO;
            in4_pol   <= POL_NO;
            out11_fn  <= FUNC_NONE;
            out11_pol <= POL_NO;
        end else begin
            in3_fn    <= safety_on ? FUNC_SAFETY_A : FUNC_NONE; // RL5 RL7
            in4_fn    <= safety_on ? FUNC_SAFETY_B : FUNC_NONE; // RL5 RL7
            in3_pol   <= safety_on ? POL_NC : POL_NO; // RL5 RL7
            in4_pol   <= safety_on ? POL_NC : POL_NO; // RL5 RL7
            out11_fn  <= mon_on ? FUNC_MONITOR : FUNC_NONE; // RL6 RL7
            out11_pol <= POL_NO; // RL6
        end
    end

    // software control registers
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            run      <= 1'b0;
            mode     <= MODE_RST;
            irq_mask <= '0;
        end else if (wr_en) begin
            if (PADDR == REG_CTRL)
                run <= PWDATA[CTRL_RUN];
            if (PADDR == REG_MODE)
                mode <= PWDATA[MODE_W-1:0];
            if (PADDR == REG_IRQ_MK)
                irq_mask <= PWDATA[IRQ_W-1:0];
        end
    end

    // sticky interrupt status, write one to clear, set wins
    assign cond[IRQ_SHUTOFF] = shutoff;
    assign cond[IRQ_TRIP]    = TRIP_ACTIVE;
    assign cond[IRQ_SKEW]    = safety_on && (a_ok ^ b_ok);
    assign evt = cond & ~cond_d;
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            cond_d     <= '0;
            irq_status <= '0;
            IRQ        <= 1'b0;
        end else begin
            cond_d <= cond;
            if (wr_en && PADDR == REG_IRQ_ST)
                irq_status <= (irq_status & ~PWDATA[IRQ_W-1:0]) | evt;
            else
                irq_status <= irq_status | evt;
            IRQ <= |(irq_status & irq_mask);
        end
    end

    // read decode
    always_comb begin
        rd_data = '0;
        rd_err  = 1'b0;
        case (PADDR)
            REG_CTRL:   rd_data[CTRL_RUN] = run;
            REG_MODE:   rd_data[MODE_W-1:0] = mode;
            REG_STATUS: rd_data[ST_TRIP:0] =
                {TRIP_ACTIVE, STOP_MONITOR_OUT, GATE_ENABLE, sync};
            REG_TRIP:   rd_data[7:0] = trip_code;
            REG_FUNC:   rd_data[23:0] = {out11_fn, in4_fn, in3_fn};
            REG_POL:    rd_data[23:0] = {out11_pol, in4_pol, in3_pol};
            REG_IRQ_ST: rd_data[IRQ_W-1:0] = irq_status;
            REG_IRQ_MK: rd_data[IRQ_W-1:0] = irq_mask;
            default:    rd_err = 1'b1;
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= '0;
        end else begin
            PREADY  <= setup;
            PSLVERR <= setup && rd_err;
            if (setup && !PWRITE)
                PRDATA <= rd_data;
        end
    end

    // checks
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESETN);

    a_gate_either_off: assert property ( // RL1
        shutoff |=> !GATE_ENABLE)
        else $error("gate on with a safety channel open");
    a_skew_no_mon: assert property ( // RL2
        safety_on && (a_ok ^ b_ok) |=> !STOP_MONITOR_OUT && !GATE_ENABLE)
        else $error("one channel open but monitor or gate active");
    a_mon_cause: assert property ( // RL3
        STOP_MONITOR_OUT |-> $past(safety_on && mon_on && !a_ok && !b_ok))
        else $error("monitor conducts without both channels open");
    a_gate_permit: assert property ( // RL4
        GATE_ENABLE |-> $past(!safety_on || (a_ok && b_ok)) && $past(run))
        else $error("gate enabled without both channels energised");
    a_input_lock: assert property ( // RL5
        safety_on ##1 safety_on |-> in3_fn == FUNC_SAFETY_A &&
        in4_fn == FUNC_SAFETY_B && in3_pol == POL_NC && in4_pol == POL_NC)
        else $error("safety inputs not forced");
    a_mon_lock: assert property ( // RL6
        mon_on |=> out11_fn == FUNC_MONITOR && out11_pol == POL_NO)
        else $error("monitor output not forced");
    a_revert_none: assert property ( // RL7
        !safety_on |=> in3_fn == FUNC_NONE && in4_pol == POL_NO)
        else $error("inputs not reverted to no function");
    a_mode_no_trip: assert property ( // RL8
        !TRIP_ACTIVE && mode == MODE_NO_TRIP && !ext_req |=> !TRIP_ACTIVE)
        else $error("trip entered in silent mode");
    a_mode_trip: assert property ( // RL9
        shutoff && mode == MODE_TRIP |=> TRIP_ACTIVE && !GATE_ENABLE &&
        trip_code == TRIP_SAFETY)
        else $error("no safety trip in trip mode");
    a_trip_rank: assert property ( // RL10
        trip_code == TRIP_SAFETY && !trip_clr |=> trip_code == TRIP_SAFETY)
        else $error("external trip replaced safety trip");
    a_shutoff_time: assert property ( // RL11
        (safety_on && !SAFETY_IN_A) [*3] ##1 safety_on |-> !GATE_ENABLE)
        else $error("gate not off within latency");
    a_lat_budget: assert property ( // RL11
        SHUTOFF_LAT_CYC <= SHUTOFF_MAX_CYC)
        else $error("shutoff latency over budget");
    a_sync_depth: assert property ( // RL14
        $past(RESETN, 2) |->
        a_ok == $past(SAFETY_IN_A, 2) && b_ok == $past(SAFETY_IN_B, 2))
        else $error("safety input not two-stage synchronised");

    c_both_open: cover property (STOP_MONITOR_OUT && !GATE_ENABLE);
    c_skew: cover property (cond[IRQ_SKEW] ##1 !STOP_MONITOR_OUT);
    c_safety_trip: cover property (TRIP_ACTIVE && trip_code == TRIP_SAFETY);
    c_ext_trip: cover property (TRIP_ACTIVE && trip_code == TRIP_EXT);
endmodule : gsss_top

// *** tb/gsss_relay_model.sv ***
// model of the external safety relay that feeds both safety channels
// assumes the bench clock; the relay changes its contacts after rising edges
`timescale 1ns/1ps
module gsss_relay_model (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // commands from the bench
    input  wire logic estop,
    input  wire logic open_a,
    input  wire logic open_b,
    // link to the block
    input  wire logic monitor,
    output logic      safety_a,
    output logic      safety_b,
    output logic      fault
);
    logic [3:0] wait_cnt;

    // a stop opens both channels together; single opens are bench faults
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            safety_a <= 1'b1;
            safety_b <= 1'b1;
        end else begin
            safety_a <= !(estop || open_a);
            safety_b <= !(estop || open_b);
        end
    end

    // a stop not confirmed by the monitor within 8 cycles is a fault
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_cnt <= 4'h0;
            fault    <= 1'b0;
        end else begin
            wait_cnt <= (estop && !monitor) ? wait_cnt + 4'h1 : 4'h0;
            if (wait_cnt == 4'h8) begin
                fault <= 1'b1;
            end
        end
    end
endmodule : gsss_relay_model

// *** tb/gsss_top_tb_top.sv ***
// self-checking bench for the safe-stop block
// assumes the apb slave answers with no wait state, pins act 3 edges later
`timescale 1ns/1ps
module gsss_top_tb_top;
    import gsss_pkg::*;
    logic              clk_sys, resetn, psel, penable, pwrite, pready;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, rd;
    logic              pslverr, err, safety_a, safety_b, safety_sw;
    logic              monitor_sw, ext_trip, gate_en, mon_out, trip_act;
    logic              irq, estop, open_a, open_b, relay_fault;
    int                n_fail, n_tests;

    gsss_top #(.SHUTOFF_MAX_CYC(8)) dut (
        .CLK_SYS(clk_sys), .RESETN(resetn), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .SAFETY_IN_A(safety_a),
        .SAFETY_IN_B(safety_b), .SAFETY_SW(safety_sw),
        .MONITOR_SW(monitor_sw), .EXT_TRIP(ext_trip),
        .GATE_ENABLE(gate_en), .STOP_MONITOR_OUT(mon_out),
        .TRIP_ACTIVE(trip_act), .IRQ(irq));
    gsss_relay_model relay (
        .clk(clk_sys), .rst_n(resetn), .estop(estop), .open_a(open_a),
        .open_b(open_b), .monitor(mon_out), .safety_a(safety_a),
        .safety_b(safety_b), .fault(relay_fault));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    task automatic stop_test;
        if (n_fail == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test

    // one apb transfer; read data and error are taken at the ready edge
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // relay answers in one edge and the block in three more
    task automatic pins(input logic e, input logic a, input logic b);
        @(posedge clk_sys);
        estop  <= e;
        open_a <= a;
        open_b <= b;
        repeat (4) @(posedge clk_sys);
        #1;
    endtask : pins

    task automatic t_reset;
        check({gate_en, mon_out, trip_act, irq}, 4'h0);
        apb(1'b0, REG_MODE, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, REG_IRQ_MK, 32'h0);
        check(rd, 32'h0);
    endtask : t_reset

    task automatic t_assign;
        apb(1'b0, REG_FUNC, 32'h0);
        check(rd, 32'h003e4e4d);
        apb(1'b1, REG_FUNC, 32'h0);
        apb(1'b0, REG_FUNC, 32'h0);
        check(rd, 32'h003e4e4d);
        apb(1'b0, REG_POL, 32'h0);
        check(rd, 32'h00000101);
        apb(1'b1, REG_CTRL, 32'h1);
        @(posedge clk_sys);
        safety_sw  <= 1'b0;
        monitor_sw <= 1'b0;
        pins(1'b0, 1'b1, 1'b1);
        check({gate_en, mon_out}, 2'b10);
        apb(1'b0, REG_FUNC, 32'h0);
        check(rd, 32'h00ffffff);
        apb(1'b0, REG_POL, 32'h0);
        check(rd, 32'h0);
        @(posedge clk_sys);
        safety_sw  <= 1'b1;
        monitor_sw <= 1'b1;
        pins(1'b0, 1'b0, 1'b0);
    endtask : t_assign

    task automatic t_table;
        for (int i = 0; i < 4; i++) begin
            pins(1'b0, i[0], i[1]);
            check(gate_en, i == 0);
            check(mon_out, i == 3);
            check(trip_act, 1'b0);
        end
        pins(1'b0, 1'b0, 1'b0);
    endtask : t_table

    task automatic t_trip;
        apb(1'b1, REG_MODE, {30'h0, MODE_TRIP});
        pins(1'b1, 1'b0, 1'b0);
        check({gate_en, trip_act}, 2'b01);
        apb(1'b0, REG_TRIP, 32'h0);
        check(rd, {24'h0, TRIP_SAFETY});
        check(relay_fault, 1'b0);
        @(posedge clk_sys);
        ext_trip <= 1'b1;
        pins(1'b0, 1'b0, 1'b0);
        apb(1'b1, REG_CTRL, 32'h3);
        pins(1'b1, 1'b0, 1'b0);
        apb(1'b0, REG_TRIP, 32'h0);
        check(rd, {24'h0, TRIP_SAFETY});
        pins(1'b0, 1'b0, 1'b0);
        apb(1'b1, REG_CTRL, 32'h3);
        apb(1'b0, REG_TRIP, 32'h0);
        check(rd, {24'h0, TRIP_EXT});
        @(posedge clk_sys);
        ext_trip <= 1'b0;
        apb(1'b1, REG_CTRL, 32'h3);
        pins(1'b0, 1'b0, 1'b0);
        check({gate_en, trip_act}, 2'b10);
    endtask : t_trip

    task automatic t_irq;
        apb(1'b1, REG_MODE, {30'h0, MODE_NO_TRIP});
        apb(1'b1, REG_IRQ_ST, 32'h7);
        pins(1'b0, 1'b1, 1'b0);
        check(irq, 1'b0);
        apb(1'b0, REG_IRQ_ST, 32'h0);
        check(rd, 32'h5);
        apb(1'b1, REG_IRQ_MK, 32'h7);
        pins(1'b0, 1'b0, 1'b0);
        check(irq, 1'b1);
        apb(1'b1, REG_IRQ_ST, 32'h7);
        pins(1'b0, 1'b0, 1'b0);
        check(irq, 1'b0);
        apb(1'b0, 12'h100, 32'h0);
        check(err, 1'b1);
        check(rd, 32'h0);
    endtask : t_irq

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        stop_test();
    end

    initial begin
        {resetn, psel, penable, pwrite, ext_trip} = 5'h0;
        {estop, open_a, open_b, safety_sw, monitor_sw} = 5'h3;
        paddr = '0;
        pwdata = '0;
        n_fail = 0;
        n_tests = 0;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        #1;
        t_reset();
        t_assign();
        t_table();
        t_trip();
        t_irq();
        stop_test();
    end
endmodule : gsss_top_tb_top
